// >>> hw/apm_map.vh
// register selection codes, mode encodings, field positions and reset values
`ifndef APM_MAP_VH
`define APM_MAP_VH

// ***************************************************************
// register selection codes, native mode
// ***************************************************************
`define APM_SEL_SPEED     4'h6
`define APM_SEL_PRODUCT   4'h7
`define APM_SEL_POSITION  4'h8
`define APM_SEL_XSTATUS   4'h9
`define APM_SEL_PORT      4'ha

// low three code bits in the compatibility modes (top bit ignored)
`define APM_SEL3_SPEED    3'h6
`define APM_SEL3_STATPROD 3'h7
`define APM_SEL3_NONE     3'h0

// ***************************************************************
// compatibility mode encodings
// ***************************************************************
`define APM_MODE_NATIVE   2'h0
`define APM_MODE_MID      2'h1
`define APM_MODE_OLDEST   2'h2

// ***************************************************************
// read buffer field positions
// ***************************************************************
`define APM_RB_HIGH_MSB   23
`define APM_RB_HIGH_LSB   16
`define APM_RB_SPEED_LSB  8

// product information byte layout
`define APM_PI_ID_MSB     7
`define APM_PI_ID_LSB     4
`define APM_PI_VER_BIT    3
`define APM_PI_NATIVE_BIT 0

// port register layout
`define APM_PORT_OUT_MSB  3
`define APM_PORT_UB_BIT   4
`define APM_PORT_FH_BIT   5

// ***************************************************************
// reset values and limits
// ***************************************************************
`define APM_POS_RESET     24'h000000
`define APM_PORT_RESET    4'h0
`define APM_RB_RESET      24'h000000
`define APM_SPEED_MAX     16'h1fff

`endif

// >>> hw/apm_sync2.v
// two flip-flop synchroniser for pin levels
module apm_sync2 #(
   parameter WIDTH = 1
) (
   input  wire             sys_clk,
   input  wire             rstn,
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   // first stage feeds only the second stage
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= {WIDTH{1'b0}};
         sync_q <= {WIDTH{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule // apm_sync2

// >>> hw/apm_pos_counter.v
// 24-bit current position counter with host load and origin clear
`include "apm_map.vh"

module apm_pos_counter #(
   parameter WIDTH = 24
) (
   input  wire             sys_clk,
   input  wire             rstn,
   input  wire             load,
   input  wire [WIDTH-1:0] load_value,
   input  wire             origin_clear,
   input  wire             pulse,
   input  wire             dir_minus,
   input  wire             pulse_count_inhibit,
   input  wire             count_reverse,
   output wire [WIDTH-1:0] position
);

   reg  [WIDTH-1:0] pos_q;
   reg  [WIDTH-1:0] pos_d;
   wire             count_down;

   // reverse swaps the sense of both directions
   assign count_down = dir_minus ^ count_reverse;

   // host load beats origin clear, which beats a pulse: the last
   // word software wrote must be what it reads back
   always @* begin
      pos_d = pos_q;
      if (load) begin
         pos_d = load_value;
      end else if (origin_clear) begin
         pos_d = {WIDTH{1'b0}};
      end else if (pulse && !pulse_count_inhibit) begin
         // natural modulo 2^WIDTH wrap in both directions
         if (count_down) begin
            pos_d = pos_q - {{(WIDTH-1){1'b0}}, 1'b1};
         end else begin
            pos_d = pos_q + {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pos_q <= `APM_POS_RESET;
      end else begin
         pos_q <= pos_d;
      end
   end

   // raw bits: signed or unsigned reading is the host's business
   assign position = pos_q;

endmodule // apm_pos_counter

// >>> hw/apm_regs.v
// axis position, status, product, port and speed register group
`include "apm_map.vh"

module apm_regs #(
   parameter [3:0] PRODUCT_ID  = 4'h5,  // arbitrary value
   parameter       VERSION_BIT = 1'b1,  // arbitrary value
   parameter       POS_WIDTH   = 24,
   parameter       SPD_WIDTH   = 16,
   parameter       MAG_WIDTH   = 8
) (
   input  wire                 sys_clk,
   input  wire                 rstn,
   // host access
   input  wire [1:0]           compat_mode,
   input  wire [3:0]           register_select_code,
   input  wire [23:0]          write_buffer,
   input  wire                 reg_write,
   input  wire                 reg_read,
   output wire [23:0]          read_buffer,
   // pulse generator side
   input  wire                 pulse_out,
   input  wire                 dir_minus,
   input  wire                 pulse_count_inhibit,
   input  wire                 count_reverse,
   input  wire                 origin_counter_clear,
   input  wire                 origin_return_active,
   input  wire                 origin_reached,
   input  wire                 axis_running,
   input  wire [SPD_WIDTH-1:0] speed_step,
   input  wire [MAG_WIDTH-1:0] speed_magnification,
   output wire [SPD_WIDTH+MAG_WIDTH-1:0] output_speed_pps,
   output wire [POS_WIDTH-1:0] position_counter,
   // status sources
   input  wire                 xst_interrupt,
   input  wire                 xst_bit14,
   input  wire                 xst_plus_position,
   input  wire                 xst_minus_position,
   input  wire                 xst_phase_zero,
   input  wire                 xst_plus_slowdown,
   input  wire                 xst_minus_slowdown,
   input  wire                 xst_start_input,
   input  wire                 xst_stop_input,
   input  wire                 xst_origin_input,
   input  wire                 xst_plus_end_limit,
   input  wire                 xst_minus_end_limit,
   // phase / port terminals
   input  wire                 port_mode,
   input  wire [3:0]           port_input_en,
   input  wire [3:0]           phase_drive,
   input  wire [3:0]           phase_port_terminal_i,
   output wire [3:0]           phase_port_terminal_o,
   output wire [3:0]           phase_port_terminal_oe,
   input  wire                 updown_bidir_pin,
   input  wire                 full_half_pin
);

   // ***************************************************************
   // declarations
   // ***************************************************************
   wire [3:0]           term_sync;
   wire [1:0]           mode_sync;
   wire [2:0]           sel_low3;
   wire                 native;
   wire                 oldest;
   wire                 mid;
   wire                 pos_load;
   wire                 port_write;
   wire                 origin_clear;
   wire [15:0]          extended_status;
   wire [7:0]           product_information;
   wire [7:0]           port_control_monitor;
   wire [15:0]          current_speed_monitor;
   reg  [3:0]           port_out_q;
   reg  [3:0]           port_out_d;
   reg  [23:0]          rbuf_q;
   reg  [23:0]          rbuf_d;
   reg  [SPD_WIDTH-1:0] speed_q;
   reg  [SPD_WIDTH-1:0] speed_d;

   // ***************************************************************
   // pin synchronisers
   // ***************************************************************

   // terminal levels come from outside; two flops before any use
   apm_sync2 #(
      .WIDTH (4)
   ) u_term_sync (
      .sys_clk  (sys_clk),
      .rstn     (rstn),
      .async_in (phase_port_terminal_i),
      .sync_out (term_sync)
   );

   // mode terminals are pins as well
   apm_sync2 #(
      .WIDTH (2)
   ) u_mode_sync (
      .sys_clk  (sys_clk),
      .rstn     (rstn),
      .async_in ({full_half_pin, updown_bidir_pin}),
      .sync_out (mode_sync)
   );

   // ***************************************************************
   // access decode
   // ***************************************************************

   // compatibility modes see only the low three code bits
   assign sel_low3 = register_select_code[2:0];
   assign native   = (compat_mode == `APM_MODE_NATIVE);
   assign mid      = (compat_mode == `APM_MODE_MID);
   assign oldest   = (compat_mode == `APM_MODE_OLDEST);

   // writes exist in native mode only; status-type codes ignore them
   assign pos_load   = reg_write && native &&
                       (register_select_code == `APM_SEL_POSITION);
   assign port_write = reg_write && native &&
                       (register_select_code == `APM_SEL_PORT);

   // origin clear only during an origin-return run with the bit set
   assign origin_clear = origin_return_active && origin_counter_clear &&
                         origin_reached;

   // ***************************************************************
   // current position counter
   // ***************************************************************

   // full 24-bit load straight from the write buffer
   apm_pos_counter #(
      .WIDTH (POS_WIDTH)
   ) u_pos (
      .sys_clk             (sys_clk),
      .rstn                (rstn),
      .load                (pos_load),
      .load_value          (write_buffer[POS_WIDTH-1:0]),
      .origin_clear        (origin_clear),
      .pulse               (pulse_out),
      .dir_minus           (dir_minus),
      .pulse_count_inhibit (pulse_count_inhibit),
      .count_reverse       (count_reverse),
      .position            (position_counter)
   );

   // ***************************************************************
   // extended status word
   // ***************************************************************

   // phase bits show the real terminal levels, not the drive intent
   assign extended_status = {
      xst_interrupt,            // 15
      xst_bit14,                // 14
      xst_plus_position,        // 13
      xst_minus_position,       // 12
      term_sync[3],             // 11 phase 4
      term_sync[2],             // 10 phase 3
      term_sync[1],             // 9  phase 2
      term_sync[0],             // 8  phase 1
      xst_phase_zero,           // 7
      xst_plus_slowdown,        // 6
      xst_minus_slowdown,       // 5
      xst_start_input,          // 4
      xst_stop_input,           // 3
      xst_origin_input,         // 2
      xst_plus_end_limit,       // 1
      xst_minus_end_limit       // 0
   };

   // ***************************************************************
   // product information byte
   // ***************************************************************

   // bits 2 and 1 are fixed zeros
   assign product_information = {
      PRODUCT_ID,
      VERSION_BIT,
      2'b00,
      native
   };

   // ***************************************************************
   // general-purpose port register
   // ***************************************************************

   // only the four output levels are stored; bits 4-5 ignore writes
   always @* begin
      port_out_d = port_out_q;
      if (port_write) begin
         port_out_d = write_buffer[`APM_PORT_OUT_MSB:0];
      end
   end

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         port_out_q <= `APM_PORT_RESET;
      end else begin
         port_out_q <= port_out_d;
      end
   end

   // port mode selects stored levels over the excitation sequence;
   // an input-configured terminal is never driven
   assign phase_port_terminal_o  = port_mode ? port_out_q : phase_drive;
   assign phase_port_terminal_oe = ~port_input_en;

   // reading returns terminal levels, so an input shows outside level
   assign port_control_monitor = {
      2'b00,
      mode_sync[1],
      mode_sync[0],
      term_sync
   };

   // ***************************************************************
   // current speed monitor
   // ***************************************************************

   // registered so the read sees one settled value; forced to zero
   // when stopped so a stale step never lingers after the stop
   always @* begin
      speed_d = {SPD_WIDTH{1'b0}};
      if (axis_running) begin
         if (speed_step > `APM_SPEED_MAX) begin
            speed_d = `APM_SPEED_MAX;
         end else begin
            speed_d = speed_step;
         end
      end
   end

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         speed_q <= {SPD_WIDTH{1'b0}};
      end else begin
         speed_q <= speed_d;
      end
   end

   assign current_speed_monitor = speed_q;

   // pulse rate for the rest of the axis; product is full width
   assign output_speed_pps = speed_q * speed_magnification;

   // ***************************************************************
   // read buffer
   // ***************************************************************

   // the buffer is loaded on a read strobe and then holds, so the
   // host may fetch it at leisure; unmapped codes load zero
   always @* begin
      rbuf_d = rbuf_q;
      if (reg_read) begin
         rbuf_d = `APM_RB_RESET;
         if (native) begin
            case (register_select_code)
               `APM_SEL_POSITION: begin
                  rbuf_d = position_counter;
               end
               `APM_SEL_XSTATUS: begin
                  rbuf_d[15:0] = extended_status;
               end
               `APM_SEL_PRODUCT: begin
                  rbuf_d[`APM_RB_HIGH_MSB:`APM_RB_HIGH_LSB] =
                     product_information;
               end
               `APM_SEL_PORT: begin
                  rbuf_d[7:0] = port_control_monitor;
               end
               `APM_SEL_SPEED: begin
                  rbuf_d[`APM_RB_HIGH_MSB:`APM_RB_SPEED_LSB] =
                     current_speed_monitor;
               end
               default: begin
                  rbuf_d = `APM_RB_RESET;
               end
            endcase
         end else if (mid) begin
            case (sel_low3)
               `APM_SEL3_STATPROD: begin
                  rbuf_d = {product_information, extended_status};
               end
               `APM_SEL3_SPEED: begin
                  rbuf_d[`APM_RB_HIGH_MSB:`APM_RB_HIGH_LSB] =
                     current_speed_monitor[7:0];
               end
               default: begin
                  rbuf_d = `APM_RB_RESET;
               end
            endcase
         end else if (oldest) begin
            // any nonzero low code gives the low status byte
            if (sel_low3 != `APM_SEL3_NONE) begin
               rbuf_d[7:0] = extended_status[7:0];
            end
         end
      end
   end

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rbuf_q <= `APM_RB_RESET;
      end else begin
         rbuf_q <= rbuf_d;
      end
   end

   assign read_buffer = rbuf_q;

endmodule // apm_regs

// >>> verif/apm_regs_asserts.sv
// assertion checker for the axis register group, bound to its ports
module apm_regs_asserts #(
   parameter POS_WIDTH = 24
) (
   input wire                 sys_clk,
   input wire                 rstn,
   input wire [1:0]           compat_mode,
   input wire [3:0]           register_select_code,
   input wire [23:0]          write_buffer,
   input wire                 reg_write,
   input wire                 reg_read,
   input wire [23:0]          read_buffer,
   input wire                 pulse_out,
   input wire                 dir_minus,
   input wire                 pulse_count_inhibit,
   input wire                 count_reverse,
   input wire                 origin_counter_clear,
   input wire                 origin_return_active,
   input wire                 origin_reached,
   input wire                 axis_running,
   input wire [POS_WIDTH-1:0] position_counter,
   input wire                 xst_interrupt,
   input wire                 xst_bit14,
   input wire                 xst_plus_position,
   input wire                 xst_minus_position,
   input wire                 xst_phase_zero,
   input wire                 xst_plus_slowdown,
   input wire                 xst_minus_slowdown,
   input wire                 xst_start_input,
   input wire                 xst_stop_input,
   input wire                 xst_origin_input,
   input wire                 xst_plus_end_limit,
   input wire                 xst_minus_end_limit,
   input wire                 port_mode,
   input wire [3:0]           phase_port_terminal_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // status fields; phase bits come through a synchroniser, so left out here
   wire [3:0] st_hi = {xst_interrupt, xst_bit14, xst_plus_position, xst_minus_position};
   wire [7:0] st_lo = {xst_phase_zero, xst_plus_slowdown, xst_minus_slowdown, xst_start_input,
                       xst_stop_input, xst_origin_input, xst_plus_end_limit, xst_minus_end_limit};
   // host load wins over origin clear, origin clear over pulses
   wire org_clr = origin_return_active && origin_counter_clear && origin_reached;
   wire step    = pulse_out && !pulse_count_inhibit && !reg_write && !org_clr;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   sequence s_rd(m, c);
      reg_read && compat_mode == m && register_select_code == c;
   endsequence
   sequence s_wr(c);
      reg_write && compat_mode == 2'h0 && register_select_code == c;
   endsequence
   AST_POS_LOAD: assert property (s_wr(4'h8)
      |=> position_counter == $past(write_buffer)) else $error("position load lost");
   AST_POS_UP: assert property (step && dir_minus == count_reverse
      |=> position_counter == $past(position_counter) + 24'h000001) else $error("count up wrong");
   AST_POS_DN: assert property (step && dir_minus != count_reverse
      |=> position_counter == $past(position_counter) - 24'h000001) else $error("count down wrong");
   AST_POS_HOLD: assert property (!reg_write && !org_clr
      && !(pulse_out && !pulse_count_inhibit) |=> $stable(position_counter))
      else $error("counter moved without cause");
   AST_ORG_CLR: assert property (org_clr && !reg_write
      |=> position_counter == 24'h000000) else $error("origin clear missed");
   AST_RD_XST: assert property (s_rd(2'h0, 4'h9)
      |=> read_buffer[23:12] == {8'h00, $past(st_hi)} && read_buffer[7:0] == $past(st_lo))
      else $error("status read wrong");
   AST_RD_OLD: assert property (reg_read && compat_mode == 2'h2
      && register_select_code[2:0] != 3'h0 |=> read_buffer == {16'h0000, $past(st_lo)})
      else $error("old mode status wrong");
   AST_RD_PROD: assert property (s_rd(2'h0, 4'h7)
      |=> read_buffer[18:0] == 19'h10000) else $error("product byte wrong");
   AST_RD_PORT: assert property (s_rd(2'h0, 4'ha)
      |=> read_buffer[23:6] == 18'h00000) else $error("port upper bits not zero");
   AST_SPD_STOP: assert property (!axis_running ##1 s_rd(2'h0, 4'h6)
      ##0 !axis_running |=> read_buffer == 24'h000000) else $error("speed not zero when stopped");
   AST_RB_STANDS: assert property (!reg_read |=> $stable(read_buffer))
      else $error("read buffer changed without read");
   AST_PORT_OUT: assert property (s_wr(4'ha) ##0 port_mode ##1 port_mode
      |-> phase_port_terminal_o == $past(write_buffer[3:0])) else $error("port output wrong");
endmodule // apm_regs_asserts

bind apm_regs apm_regs_asserts #(.POS_WIDTH(POS_WIDTH)) i_apm_regs_asserts (
   .sys_clk, .rstn, .compat_mode, .register_select_code, .write_buffer, .reg_write, .reg_read,
   .read_buffer, .pulse_out, .dir_minus, .pulse_count_inhibit, .count_reverse,
   .origin_counter_clear, .origin_return_active, .origin_reached, .axis_running,
   .position_counter, .xst_interrupt, .xst_bit14, .xst_plus_position, .xst_minus_position,
   .xst_phase_zero, .xst_plus_slowdown, .xst_minus_slowdown, .xst_start_input, .xst_stop_input,
   .xst_origin_input, .xst_plus_end_limit, .xst_minus_end_limit, .port_mode,
   .phase_port_terminal_o);

// >>> verif/apm_host.sv
// host processor model issuing register writes and reads
module apm_host (
   input  wire         sys_clk,
   input  wire  [23:0] read_buffer,
   output logic [1:0]  compat_mode,
   output logic [3:0]  register_select_code,
   output logic [23:0] write_buffer,
   output logic        reg_write,
   output logic        reg_read
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle bus at time zero
   initial begin
      compat_mode = 2'h0;
      register_select_code = 4'h0;
      write_buffer = 24'h000000;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end
   task set_mode(input logic [1:0] m);
      @(negedge sys_clk);
      compat_mode = m;
   endtask
   // code and data held across the taking edge, scrambled once released
   task wr(input logic [3:0] c, input logic [23:0] v);
      @(negedge sys_clk);
      register_select_code = c;
      write_buffer = v;
      reg_write = 1'b1;
      @(negedge sys_clk);
      reg_write = 1'b0;
      register_select_code = ~c;
      write_buffer = ~v;
   endtask
   task rd(input logic [3:0] c, output logic [23:0] v);
      @(negedge sys_clk);
      register_select_code = c;
      reg_read = 1'b1;
      @(negedge sys_clk);
      reg_read = 1'b0;
      register_select_code = ~c;
      v = read_buffer;
   endtask
endmodule // apm_host

// >>> verif/tb_top.sv
// self-checking testbench for the axis register group
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam [3:0] PID = 4'h3; // arbitrary value
   localparam       VER = 1'b0; // arbitrary value
   logic        sys_clk = 1'b0;
   logic        rstn = 1'b0;
   logic        pulse_out = 1'b0;
   logic        dir_minus = 1'b0;
   logic        pulse_count_inhibit = 1'b0;
   logic        count_reverse = 1'b0;
   logic        origin_counter_clear = 1'b0;
   logic        origin_return_active = 1'b0;
   logic        origin_reached = 1'b0;
   logic        axis_running = 1'b0;
   logic [15:0] speed_step = 16'h0000;
   logic [7:0]  speed_magnification = 8'h00;
   logic [11:0] xs = 12'h000;
   logic        port_mode = 1'b0;
   logic [3:0]  port_input_en = 4'h0;
   logic [3:0]  phase_drive = 4'h0;
   logic [3:0]  ext_lvl = 4'h0;
   logic        updown_bidir_pin = 1'b0;
   logic        full_half_pin = 1'b0;
   logic [23:0] d;
   wire  [1:0]  compat_mode;
   wire  [3:0]  register_select_code;
   wire  [23:0] write_buffer;
   wire  [23:0] read_buffer;
   wire  [23:0] output_speed_pps;
   wire  [23:0] position_counter;
   wire         reg_write;
   wire         reg_read;
   wire  [3:0]  term_o;
   wire  [3:0]  term_oe;
   // terminal level: device drives where enabled, outside level elsewhere
   wire  [3:0]  term = (term_oe & term_o) | (~term_oe & ext_lvl);
   integer      n_mismatch = 0;
   integer      tests_run = 0;
   integer      cyc = 0;
   integer      i;
   apm_regs #(.PRODUCT_ID(PID), .VERSION_BIT(VER)) i_apm_regs (
      .sys_clk, .rstn, .compat_mode, .register_select_code, .write_buffer, .reg_write,
      .reg_read, .read_buffer, .pulse_out, .dir_minus, .pulse_count_inhibit, .count_reverse,
      .origin_counter_clear, .origin_return_active, .origin_reached, .axis_running,
      .speed_step, .speed_magnification, .output_speed_pps, .position_counter,
      .xst_interrupt(xs[11]), .xst_bit14(xs[10]), .xst_plus_position(xs[9]),
      .xst_minus_position(xs[8]), .xst_phase_zero(xs[7]), .xst_plus_slowdown(xs[6]),
      .xst_minus_slowdown(xs[5]), .xst_start_input(xs[4]), .xst_stop_input(xs[3]),
      .xst_origin_input(xs[2]), .xst_plus_end_limit(xs[1]), .xst_minus_end_limit(xs[0]),
      .port_mode, .port_input_en, .phase_drive, .phase_port_terminal_i(term),
      .phase_port_terminal_o(term_o), .phase_port_terminal_oe(term_oe), .updown_bidir_pin,
      .full_half_pin);
   apm_host i_apm_host (
      .sys_clk, .read_buffer, .compat_mode, .register_select_code, .write_buffer, .reg_write,
      .reg_read);
   always #5 sys_clk = ~sys_clk;
   // hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge sys_clk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         n_mismatch = n_mismatch + 1;
         finish_test;
      end
   end
   task finish_test;
      if (n_mismatch == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [23:0] seen, input logic [23:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task rd_chk(input logic [3:0] c, input logic [23:0] exp);
      i_apm_host.rd(c, d);
      chk(d, exp);
   endtask
   // one-cycle output pulse or origin arrival
   task pls(input logic org, input logic m);
      @(negedge sys_clk);
      dir_minus = m;
      if (org) origin_reached = 1'b1;
      else pulse_out = 1'b1;
      @(negedge sys_clk);
      origin_reached = 1'b0;
      pulse_out = 1'b0;
   endtask
   // wrap both ways, reversed direction, inhibit, signed boundary
   task t_count;
      i_apm_host.wr(4'h8, 24'hffffff);
      rd_chk(4'h8, 24'hffffff);
      pls(1'b0, 1'b0);
      rd_chk(4'h8, 24'h000000);
      pls(1'b0, 1'b1);
      rd_chk(4'h8, 24'hffffff);
      count_reverse = 1'b1;
      pls(1'b0, 1'b0);
      rd_chk(4'h8, 24'hfffffe);
      count_reverse = 1'b0;
      pulse_count_inhibit = 1'b1;
      pls(1'b0, 1'b0);
      rd_chk(4'h8, 24'hfffffe);
      pulse_count_inhibit = 1'b0;
      i_apm_host.wr(4'h8, 24'h800000);
      pls(1'b0, 1'b1);
      rd_chk(4'h8, 24'h7fffff);
   endtask
   // origin clear only with its bit set; writes refused outside native mode
   task t_origin;
      i_apm_host.wr(4'h8, 24'h000123);
      origin_return_active = 1'b1;
      pls(1'b1, 1'b0);
      rd_chk(4'h8, 24'h000123);
      origin_counter_clear = 1'b1;
      pls(1'b1, 1'b0);
      rd_chk(4'h8, 24'h000000);
      origin_return_active = 1'b0;
      i_apm_host.set_mode(2'h2);
      i_apm_host.wr(4'h8, 24'h0000aa);
      i_apm_host.set_mode(2'h0);
      rd_chk(4'h8, 24'h000000);
   endtask
   task t_port;
      port_mode = 1'b1;
      updown_bidir_pin = 1'b1;
      i_apm_host.wr(4'ha, 24'h0000ff);
      repeat (3) @(negedge sys_clk);
      chk({20'h00000, term}, 24'h00000f);
      rd_chk(4'ha, 24'h00001f);
      i_apm_host.set_mode(2'h2);
      i_apm_host.wr(4'ha, 24'h000000);
      i_apm_host.set_mode(2'h0);
      chk({20'h00000, term}, 24'h00000f);
      i_apm_host.wr(4'ha, 24'h0000f5);
      port_input_en = 4'h3;
      ext_lvl = 4'ha;
      updown_bidir_pin = 1'b0;
      full_half_pin = 1'b1;
      repeat (3) @(negedge sys_clk);
      rd_chk(4'ha, 24'h000026);
      port_mode = 1'b0;
      port_input_en = 4'h0;
      phase_drive = 4'h9;
      @(negedge sys_clk);
      chk({20'h00000, term}, 24'h000009);
   endtask
   // status in native, oldest and mid modes; product byte
   task t_status;
      xs = 12'ha5c;
      port_input_en = 4'hf;
      repeat (3) @(negedge sys_clk);
      // terminals are all inputs here, so phase bits show the outside level
      rd_chk(4'h9, 24'h00aa5c);
      i_apm_host.wr(4'h9, 24'hffffff);
      rd_chk(4'h9, 24'h00aa5c);
      rd_chk(4'h7, {PID, VER, 3'b001, 16'h0000});
      i_apm_host.set_mode(2'h2);
      for (i = 0; i < 16; i = i + 1)
         rd_chk(i[3:0], (i[2:0] == 3'h0) ? 24'h000000 : 24'h00005c);
      i_apm_host.set_mode(2'h1);
      rd_chk(4'hf, {PID, VER, 3'b000, 16'haa5c});
      i_apm_host.set_mode(2'h3);
      rd_chk(4'h8, 24'h000000);
      i_apm_host.set_mode(2'h0);
      rd_chk(4'h0, 24'h000000);
      // inverse pattern so every status input is seen at both levels
      xs = 12'h5a3;
      rd_chk(4'h9, 24'h005aa3);
   endtask
   task t_speed;
      axis_running = 1'b1;
      speed_magnification = 8'h03;
      speed_step = 16'h1234;
      repeat (2) @(negedge sys_clk);
      rd_chk(4'h6, 24'h123400);
      chk(output_speed_pps, 24'h00369c);
      speed_step = 16'h2000;
      repeat (2) @(negedge sys_clk);
      rd_chk(4'h6, 24'h1fff00);
      // mid mode shows the low speed byte; upper magnification bits exercised
      speed_magnification = 8'hfc;
      i_apm_host.set_mode(2'h1);
      rd_chk(4'he, 24'hff0000);
      i_apm_host.set_mode(2'h0);
      chk(output_speed_pps, 24'h1f7f04);
      axis_running = 1'b0;
      repeat (2) @(negedge sys_clk);
      rd_chk(4'h6, 24'h000000);
   endtask
   initial begin
      repeat (12) @(negedge sys_clk);
      rstn = 1'b1;
      rd_chk(4'h8, 24'h000000);
      t_count;
      t_origin;
      t_port;
      t_status;
      t_speed;
      finish_test;
   end
endmodule // tb_top
